// *** hw/ras_pkg.sv ***
package ras_pkg;

	// fixed upper part of the 7-bit target address
	localparam logic [2:0] TGT_ADDR_HI        = 3'h3;
	// reset value of the user address bits held by the storage side
	localparam logic [3:0] USER_ADDR_DEFAULT  = 4'h6;
	// last location an auto-incremented write may still change
	localparam logic [7:0] WR_LAST_ADDR       = 8'h4f;
	// function command location: direct writes only
	localparam logic [7:0] FUNCTION_COMMAND_BYTE_ADDR          = 8'hfe;
	// last location of the pointer space
	localparam logic [7:0] PTR_LAST           = 8'hff;
	// value returned once a read runs past the pointer space
	localparam logic [7:0] PAST_END_DATA      = 8'hff;
	localparam logic [7:0] PTR_RESET          = 8'h00;
	localparam logic [7:0] BYTE_RESET         = 8'h00;
	// bits per byte before the acknowledge bit
	localparam logic [3:0] BYTE_BITS          = 4'h8;
	localparam logic [3:0] CNT_RESET          = 4'h0;
	localparam int         WR_FIFO_DEPTH      = 32;
	localparam int         SYNC_STAGES        = 2;
	// index of the pins inside the synchroniser bank
	localparam int         PIN_SCL            = 0;
	localparam int         PIN_SDA            = 1;
	localparam int         PIN_COUNT          = 2;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'b0000,
		ST_ADDR      = 4'b0001,
		ST_ADDR_ACK  = 4'b0010,
		ST_PTR       = 4'b0011,
		ST_PTR_ACK   = 4'b0100,
		ST_WDATA     = 4'b0101,
		ST_WDATA_ACK = 4'b0110,
		ST_RDATA     = 4'b0111,
		ST_RDATA_ACK = 4'b1000,
		ST_IGNORE    = 4'b1001
	} ras_state_t;

	// one byte headed for the shadow storage
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} ras_wr_item_t;

	localparam ras_wr_item_t WR_ITEM_RESET = '{addr: 8'h00, data: 8'h00};

endpackage

// *** hw/ras_fifo.sv ***
module ras_fifo
	import ras_pkg::*;
#(
	parameter int WIDTH = $bits(ras_wr_item_t),
	parameter int DEPTH = WR_FIFO_DEPTH
) (
	input  wire logic             sys_clk,
	input  wire logic             resetn,
	input  wire logic             clk_en,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	// the output stage is a register so the consumer sees flop outputs
	assign in_ready = (count < (AW+1)'(DEPTH));
	assign push     = in_valid && in_ready;
	assign pop      = (count != '0) && (!out_valid || out_ready);

	always_ff @(posedge sys_clk) begin
		if (clk_en && push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (clk_en) begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (clk_en) begin
			if (pop) begin
				out_valid <= 1'b1;
				out_data  <= mem[rd_ptr];
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
		end
	end

endmodule

// *** hw/ras_slave.sv ***
// What this block does
// - write: address, pointer byte, data bytes, acknowledged unless write buffer full
// - pointer loads from byte after write address
// - in writes, master owns data line except acknowledge bits
// - device drives data line from address acknowledge
// - master not-acknowledge hands data line back
// - pointer increments after each written byte
// - auto-incremented writes past 4Fh are dropped
// - writes to read-only or reserved locations dropped
// - command location FEh accepts only direct writes
// - cut-short or refused bytes are never stored
// - writes reach the shadow copy only
// - read starts at pointer, most significant first
// - pointer increments after each byte sent
// - reads past FFh return FFh
// - reserved locations read back undefined data
// - target address is 011 plus user bits
// - idle device acknowledges start plus matching address
// - eight bits most significant first, then acknowledge
module ras_slave
	import ras_pkg::*;
#(
	parameter int FIFO_DEPTH = WR_FIFO_DEPTH
) (
	input  wire logic         sys_clk,
	input  wire logic         resetn,
	input  wire logic         clk_en,
	input  wire logic         scl_in,
	input  wire logic         sda_in,
	output logic              sda_out,
	output logic              sda_oe,
	input  wire logic [3:0]   user_address_bits,
	output logic [7:0]        mem_ptr,
	input  wire logic         loc_read_only,
	input  wire logic [7:0]   rd_data,
	output logic              rd_strobe,
	output ras_wr_item_t      wr_item,
	output logic              wr_valid,
	input  wire logic         wr_ready,
	output logic              busy
);

	logic [PIN_COUNT-1:0] pin_raw;
	logic [PIN_COUNT-1:0] pin_meta;
	logic [PIN_COUNT-1:0] pin_sync;
	logic                 scl_q;
	logic                 sda_q;
	logic                 scl_rise;
	logic                 scl_fall;
	logic                 bus_start;
	logic                 bus_stop;

	ras_state_t           state;
	logic [3:0]           bit_cnt;
	logic [7:0]           rx_shift;
	logic [7:0]           tx_shift;
	logic                 read_dir;
	logic                 first_byte;
	logic                 past_end;
	logic                 master_nak;
	logic                 keep_byte;
	ras_wr_item_t         pend_item;

	logic                 fifo_in_valid;
	logic                 fifo_in_ready;
	ras_wr_item_t         fifo_in_data;

	// a byte is stored only if its location takes bus writes at all
	function automatic logic write_allowed(input logic [7:0] addr, input logic direct,
		input logic ro, input logic beyond);
		logic ok;
		ok = !ro && !beyond;
		if (addr == FUNCTION_COMMAND_BYTE_ADDR) begin
			ok = ok && direct;
		end else if (!direct && (addr > WR_LAST_ADDR)) begin
			ok = 1'b0;
		end
		return ok;
	endfunction

	function automatic logic addr_match(input logic [7:0] rx, input logic [3:0] user_bits);
		return rx[7:1] == {TGT_ADDR_HI, user_bits};
	endfunction

	// first bit of a freshly loaded byte, same source as the transmit load
	function automatic logic rd_data_bit7();
		return past_end ? PAST_END_DATA[7] : rd_data[7];
	endfunction

	// both bus lines are asynchronous to sys_clk
	assign pin_raw[PIN_SCL] = scl_in;
	assign pin_raw[PIN_SDA] = sda_in;

	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					pin_meta[gi] <= 1'b1;
					pin_sync[gi] <= 1'b1;
				end else if (clk_en) begin
					pin_meta[gi] <= pin_raw[gi];
					pin_sync[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (clk_en) begin
			scl_q <= pin_sync[PIN_SCL];
			sda_q <= pin_sync[PIN_SDA];
		end
	end

	assign scl_rise  = pin_sync[PIN_SCL] && !scl_q;
	assign scl_fall  = !pin_sync[PIN_SCL] && scl_q;
	// data moving while the clock stays high marks start or stop
	assign bus_start = pin_sync[PIN_SCL] && scl_q && sda_q && !pin_sync[PIN_SDA];
	assign bus_stop  = pin_sync[PIN_SCL] && scl_q && !sda_q && pin_sync[PIN_SDA];

	// protocol sequencer
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
		end else if (clk_en) begin
			if (bus_start) begin
				state <= ST_ADDR;
			end else if (bus_stop) begin
				state <= ST_IDLE;
			end else if (scl_fall) begin
				case (state)
					ST_ADDR: begin
						if (bit_cnt == BYTE_BITS) begin
							if (addr_match(rx_shift, user_address_bits)) begin
								state <= ST_ADDR_ACK;
							end else begin
								state <= ST_IGNORE;
							end
						end
					end
					ST_ADDR_ACK: begin
						state <= read_dir ? ST_RDATA : ST_PTR;
					end
					ST_PTR: begin
						if (bit_cnt == BYTE_BITS) begin
							state <= ST_PTR_ACK;
						end
					end
					ST_PTR_ACK: begin
						state <= ST_WDATA;
					end
					ST_WDATA: begin
						if (bit_cnt == BYTE_BITS) begin
							// a full buffer refuses the byte instead of losing it
							state <= fifo_in_ready ? ST_WDATA_ACK : ST_IGNORE;
						end
					end
					ST_WDATA_ACK: begin
						state <= ST_WDATA;
					end
					ST_RDATA: begin
						if (bit_cnt == BYTE_BITS) begin
							state <= ST_RDATA_ACK;
						end
					end
					ST_RDATA_ACK: begin
						state <= master_nak ? ST_IGNORE : ST_RDATA;
					end
					default: begin
						state <= state;
					end
				endcase
			end
		end
	end

	// bit counting and receive shifting, sampled on the rising clock edge
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bit_cnt  <= CNT_RESET;
			rx_shift <= BYTE_RESET;
		end else if (clk_en) begin
			if (bus_start) begin
				bit_cnt <= CNT_RESET;
			end else if (scl_rise) begin
				case (state)
					ST_ADDR, ST_PTR, ST_WDATA: begin
						rx_shift <= {rx_shift[6:0], pin_sync[PIN_SDA]};
						bit_cnt  <= bit_cnt + 4'h1;
					end
					ST_RDATA: begin
						bit_cnt <= bit_cnt + 4'h1;
					end
					default: begin
						bit_cnt <= bit_cnt;
					end
				endcase
			end else if (scl_fall && (bit_cnt == BYTE_BITS)) begin
				bit_cnt <= CNT_RESET;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			read_dir   <= 1'b0;
			master_nak <= 1'b0;
		end else if (clk_en) begin
			if (state == ST_ADDR && scl_fall && bit_cnt == BYTE_BITS) begin
				read_dir <= rx_shift[0];
			end
			if (state == ST_RDATA_ACK && scl_rise) begin
				master_nak <= pin_sync[PIN_SDA];
			end
		end
	end

	// memory pointer: loaded by the pointer byte, stepped after each byte
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mem_ptr    <= PTR_RESET;
			past_end   <= 1'b0;
			first_byte <= 1'b0;
		end else if (clk_en && scl_fall) begin
			if (state == ST_PTR && bit_cnt == BYTE_BITS) begin
				mem_ptr    <= rx_shift;
				past_end   <= 1'b0;
				first_byte <= 1'b1;
			end else if ((state == ST_WDATA || state == ST_RDATA) && bit_cnt == BYTE_BITS) begin
				// wrap is harmless: past_end then masks reads and writes
				mem_ptr  <= mem_ptr + 8'h01;
				past_end <= past_end || (mem_ptr == PTR_LAST);
			end else if (state == ST_WDATA_ACK) begin
				first_byte <= 1'b0;
			end
		end
	end

	// write filtering decided with the byte's own address, before the step
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			keep_byte <= 1'b0;
			pend_item <= WR_ITEM_RESET;
		end else if (clk_en && scl_fall && state == ST_WDATA && bit_cnt == BYTE_BITS) begin
			keep_byte      <= write_allowed(mem_ptr, first_byte, loc_read_only, past_end);
			pend_item.addr <= mem_ptr;
			pend_item.data <= rx_shift;
		end
	end

	// the byte is pushed only once its acknowledge clock has completed
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fifo_in_valid <= 1'b0;
			fifo_in_data  <= WR_ITEM_RESET;
		end else if (clk_en) begin
			fifo_in_valid <= scl_fall && state == ST_WDATA_ACK && keep_byte;
			fifo_in_data  <= pend_item;
		end
	end

	// transmit byte load and shift, driven on falling clock edges
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tx_shift  <= BYTE_RESET;
			rd_strobe <= 1'b0;
		end else if (clk_en) begin
			rd_strobe <= 1'b0;
			if (scl_fall && ((state == ST_ADDR_ACK && read_dir) ||
				(state == ST_RDATA_ACK && !master_nak))) begin
				// reserved locations simply pass whatever storage returns
				tx_shift  <= past_end ? PAST_END_DATA : rd_data;
				rd_strobe <= 1'b1;
			end else if (scl_fall && state == ST_RDATA && bit_cnt != BYTE_BITS) begin
				tx_shift <= {tx_shift[6:0], 1'b1};
			end
		end
	end

	// open-drain data line: only ever pulled low, released for a one
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sda_oe <= 1'b0;
		end else if (clk_en) begin
			if (bus_start || bus_stop) begin
				sda_oe <= 1'b0;
			end else if (scl_fall) begin
				case (state)
					ST_ADDR: begin
						sda_oe <= (bit_cnt == BYTE_BITS) &&
							addr_match(rx_shift, user_address_bits);
					end
					ST_ADDR_ACK: begin
						sda_oe <= read_dir && !rd_data_bit7();
					end
					ST_PTR: begin
						sda_oe <= (bit_cnt == BYTE_BITS);
					end
					ST_WDATA: begin
						sda_oe <= (bit_cnt == BYTE_BITS) && fifo_in_ready;
					end
					ST_RDATA: begin
						if (bit_cnt == BYTE_BITS) begin
							sda_oe <= 1'b0;
						end else begin
							sda_oe <= !tx_shift[6];
						end
					end
					ST_RDATA_ACK: begin
						sda_oe <= !master_nak && !rd_data_bit7();
					end
					default: begin
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sda_out <= 1'b0;
			busy    <= 1'b0;
		end else if (clk_en) begin
			sda_out <= 1'b0;
			busy    <= (state != ST_IDLE) && (state != ST_IGNORE);
		end
	end

	ras_fifo #(
		.WIDTH ($bits(ras_wr_item_t)),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.clk_en    (clk_en),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_data),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  (wr_item)
	);

endmodule

// *** dv/ras_slave_assertions.sv ***
module ras_slave_chk
	import ras_pkg::*;
#(
	parameter int FIFO_DEPTH = WR_FIFO_DEPTH
) (
	input  wire logic         sys_clk,
	input  wire logic         resetn,
	input  wire logic         clk_en,
	input  wire logic         scl_in,
	input  wire logic         sda_in,
	input  wire logic         sda_out,
	input  wire logic         sda_oe,
	input  wire logic [3:0]   user_address_bits,
	input  wire logic [7:0]   mem_ptr,
	input  wire logic         loc_read_only,
	input  wire logic [7:0]   rd_data,
	input  wire logic         rd_strobe,
	input  wire ras_wr_item_t wr_item,
	input  wire logic         wr_valid,
	input  wire logic         wr_ready,
	input  wire logic         busy
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	a_out_low: assert property (sda_out == 1'b0)
		else $error("sda drive value not low");
	a_ack_phase: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
		else $error("sda driven while scl high");
	a_release_phase: assert property ($fell(sda_oe) |-> !scl_in)
		else $error("sda released while scl high");
	a_ack_hold: assert property ($rose(sda_oe) |-> sda_oe [*4])
		else $error("sda drive too short");
	a_drive_busy: assert property ($rose(sda_oe) |-> busy)
		else $error("sda driven outside a transaction");
	a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_item))
		else $error("write item dropped or changed before taken");
	a_strobe_pulse: assert property (rd_strobe |=> !rd_strobe)
		else $error("read strobe longer than one cycle");
	a_strobe_busy: assert property (rd_strobe |-> busy)
		else $error("read byte loaded while idle");
	a_ptr_busy: assert property ($changed(mem_ptr) |-> busy || $past(busy))
		else $error("pointer moved while idle");

	c_read: cover property (rd_strobe);
	c_stall: cover property ((wr_valid && !wr_ready) [*8]);
	c_end: cover property ($fell(busy));
endmodule

bind ras_slave ras_slave_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
	.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.user_address_bits(user_address_bits), .mem_ptr(mem_ptr),
	.loc_read_only(loc_read_only), .rd_data(rd_data), .rd_strobe(rd_strobe),
	.wr_item(wr_item), .wr_valid(wr_valid), .wr_ready(wr_ready), .busy(busy)
);

// *** dv/ras_master_model.sv ***
module ras_master_model (
	input  wire logic sys_clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_low
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic wq(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// also serves as repeated start; the wait lets a slave ack release first
	task automatic start();
		sda_low = 1'b0;
		wq(8);
		scl = 1'b1;
		wq(8);
		sda_low = 1'b1;
		wq(8);
		scl = 1'b0;
	endtask

	task automatic stop();
		sda_low = 1'b1;
		wq(8);
		scl = 1'b1;
		wq(8);
		sda_low = 1'b0;
		wq(8);
	endtask

	// data moves only mid-low, so scl high never sees sda change
	task automatic bitx(input logic b, output logic r);
		wq(2);
		sda_low = !b;
		wq(2);
		scl = 1'b1;
		wq(2);
		r = sda_line;
		wq(2);
		scl = 1'b0;
	endtask

	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask

	task automatic get(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			bitx(1'b1, r);
			d = {d[6:0], r};
		end
		bitx(!ack, r);
	endtask
endmodule

// *** dv/tb_i2c_register_access_slave.sv ***
module tb_i2c_register_access_slave
	import ras_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] WR_ADDR = {TGT_ADDR_HI, USER_ADDR_DEFAULT, 1'b0};
	localparam logic [7:0] RD_ADDR = {TGT_ADDR_HI, USER_ADDR_DEFAULT, 1'b1};
	logic         sys_clk, resetn, scl, sda_low, sda_out, sda_oe, rd_strobe;
	logic         wr_valid, wr_ready, busy, loc_read_only;
	logic [3:0]   user_address_bits;
	logic [7:0]   mem_ptr, rd_data;
	ras_wr_item_t wr_item;
	ras_wr_item_t log_q[$];
	int           mismatches, checked, cycles;
	wire          sda_line = !(sda_low | sda_oe);

	ras_slave #(.FIFO_DEPTH(WR_FIFO_DEPTH)) dut (.sys_clk(sys_clk), .resetn(resetn),
		.clk_en(1'b1), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .user_address_bits(user_address_bits), .mem_ptr(mem_ptr),
		.loc_read_only(loc_read_only), .rd_data(rd_data), .rd_strobe(rd_strobe),
		.wr_item(wr_item), .wr_valid(wr_valid), .wr_ready(wr_ready), .busy(busy));
	ras_master_model mst (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

	function automatic logic [7:0] mem_val(input logic [7:0] a);
		return a ^ 8'ha5;
	endfunction

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// storage stand-in: byte content is a fixed pattern, 30h is read-only
	always @(negedge sys_clk) begin
		rd_data <= mem_val(mem_ptr);
		loc_read_only <= (mem_ptr == 8'h30);
	end
	always @(posedge sys_clk) if (wr_valid && wr_ready) log_q.push_back(wr_item);

	task automatic give_verdict();
		if (mismatches == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wr_ptr(input logic [7:0] p);
		logic a;
		mst.start();
		mst.put(WR_ADDR, a);
		chk(a, 1'b1);
		mst.put(p, a);
		chk(a, 1'b1);
		chk(16'(mem_ptr), 16'(p));
	endtask

	task automatic wr_seq(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
		logic a;
		wr_ptr(p);
		mst.put(d0, a);
		chk(a, 1'b1);
		mst.put(d1, a);
		chk(a, 1'b1);
		mst.stop();
	endtask

	task automatic t_write();
		log_q.delete();
		wr_seq(8'h2f, 8'h11, 8'h30);
		wr_seq(8'h4f, 8'h44, 8'h55);
		wr_seq(FUNCTION_COMMAND_BYTE_ADDR, 8'h88, 8'h99);
		repeat (40) @(negedge sys_clk);
		chk(16'(log_q.size()), 16'h0003);
		chk(log_q[0], 16'h2f11);
		chk(log_q[1], 16'h4f44);
		chk(log_q[2], 16'hfe88);
	endtask

	task automatic t_addr();
		logic a;
		mst.start();
		mst.put({TGT_ADDR_HI, 4'h5, 1'b0}, a);
		chk(a, 1'b0);
		mst.stop();
		user_address_bits = 4'h5;
		mst.start();
		mst.put({TGT_ADDR_HI, 4'h5, 1'b0}, a);
		chk(a, 1'b1);
		mst.stop();
		user_address_bits = USER_ADDR_DEFAULT;
	endtask

	task automatic t_read(input logic [7:0] p, input int n);
		logic a;
		logic [7:0] d;
		logic [8:0] s;
		wr_ptr(p);
		mst.start();
		mst.put(RD_ADDR, a);
		chk(a, 1'b1);
		for (int i = 0; i < n; i++) begin
			s = p + i;
			mst.get(i != n - 1, d);
			chk(d, s > PTR_LAST ? PAST_END_DATA : mem_val(s[7:0]));
		end
		// for the 90h read, the byte after the last one read would start with a zero if loaded
		repeat (4) @(negedge sys_clk);
		chk(sda_oe, 1'b0);
		mst.stop();
	endtask

	task automatic t_partial();
		logic r;
		log_q.delete();
		wr_ptr(8'h20);
		for (int i = 0; i < 4; i++) mst.bitx(1'b1, r);
		mst.stop();
		repeat (40) @(negedge sys_clk);
		chk(16'(log_q.size()), 16'h0000);
	endtask

	// storage stalls until the buffer refuses, then drains it
	task automatic t_full();
		logic a;
		int n;
		log_q.delete();
		wr_ready = 1'b0;
		wr_ptr(8'h00);
		a = 1'b1;
		n = 0;
		while (a && n < 40) begin
			mst.put(8'(n), a);
			if (a) n++;
		end
		chk(16'(n), 16'(WR_FIFO_DEPTH + 1));
		mst.stop();
		wr_ready = 1'b1;
		repeat (60) @(negedge sys_clk);
		chk(16'(log_q.size()), 16'(WR_FIFO_DEPTH + 1));
		chk(log_q[WR_FIFO_DEPTH], 16'h2020);
	endtask

	initial begin
		resetn = 1'b0;
		user_address_bits = USER_ADDR_DEFAULT;
		wr_ready = 1'b1;
		repeat (2) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (8) @(negedge sys_clk);
		chk({busy, wr_valid, sda_oe}, 16'h0000);
		t_write();
		t_addr();
		t_read(8'h90, 3);
		t_read(8'hfe, 4);
		t_partial();
		t_full();
		give_verdict();
	end
endmodule
